// ==== hdl/tpgd_pkg.sv ====
// Purpose: shared constants and types of the gate drive protection block
// Assumes: 10 MHz system clock
// Notes: times are kept in their own units, cycle counts derive from them
package tpgd_pkg;
	localparam int TPGD_CLK_HZ = 10_000_000;
	localparam int TPGD_NCH = 6;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int TPGD_OE_LOW_US = 1000;
	localparam int TPGD_OE_LOW_CYC = TPGD_OE_LOW_US * (TPGD_CLK_HZ / 1_000_000);
	localparam int TPGD_LINK_OFF_US = 5000;
	localparam int TPGD_LINK_OFF_CYC = TPGD_LINK_OFF_US * (TPGD_CLK_HZ / 1_000_000);
	localparam int TPGD_UV_QUAL_NS = 10000;
	localparam int TPGD_UV_QUAL_CYC = (TPGD_UV_QUAL_NS * (TPGD_CLK_HZ / 1_000_000) + 999) / 1000;
	// ----------------------------------------
	// configuration byte layout and reset values
	// ----------------------------------------
	localparam int TPGD_CFG_THR_LSB = 0;
	localparam int TPGD_CFG_SC_EN = 2;
	localparam int TPGD_CFG_UV_EN = 3;
	localparam int TPGD_CFG_AMP_OFF = 6;
	localparam int TPGD_CFG_SLEEP = 7;
	localparam logic [7:0] TPGD_CFG_RST = 8'h0c;
	// short threshold in mV by select code
	localparam logic [10:0] TPGD_THR_MV [4] = '{11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8};
	// ----------------------------------------
	// link messages
	// ----------------------------------------
	localparam logic [7:0] TPGD_STAT0_ID = 8'h85;
	localparam logic [7:0] TPGD_STAT1_ID = 8'h86;
	localparam logic [7:0] TPGD_OT_BITS = 8'h04;
	localparam int TPGD_S1_UV_BIT = 2;
	localparam int TPGD_S1_SC_BIT = 3;
	typedef enum logic [1:0] {
		TPGD_OPER = 2'b00,
		TPGD_STBY = 2'b01,
		TPGD_SLEEP = 2'b11
	} tpgd_state_t;
endpackage

// ==== hdl/tpgd_chan_if.sv ====
// Purpose: per-driver signal bundle between control and driver channel
// Assumes: one instance per gate driver
// Notes: ctl side is the top, chan side the driver channel
`timescale 1ns/1ps
`default_nettype none
interface tpgd_chan_if;
	logic cmd;
	logic kill;
	logic uv_en;
	logic sc_en;
	logic uv_raw;
	logic sc_raw;
	logic gate;
	logic uv_hit;
	logic sc_hit;
	modport ctl(output cmd, kill, uv_en, sc_en, uv_raw, sc_raw, input gate, uv_hit, sc_hit);
	modport chan(input cmd, kill, uv_en, sc_en, uv_raw, sc_raw, output gate, uv_hit, sc_hit);
endinterface
`default_nettype wire

// ==== hdl/tpgd_chan.sv ====
// Purpose: one gate driver channel with bias undervoltage qualification and short detect
// Assumes: inputs already synchronised by the top
// Notes: hits are raw; latching lives in the top
`timescale 1ns/1ps
`default_nettype none
module tpgd_chan #(
	parameter int QUAL_CYC = tpgd_pkg::TPGD_UV_QUAL_CYC
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	tpgd_chan_if.chan ch // driver bundle
);
	import tpgd_pkg::*;
	localparam int CW = $clog2(QUAL_CYC + 1);
	logic [CW-1:0] uv_cnt;

	initial begin
		if (QUAL_CYC < 1) $error("qualification count must be at least one");
	end

	// gate follows its command unless killed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ch.gate <= 1'b0;
		end else begin
			ch.gate <= ch.cmd & ~ch.kill; // R1 R3 R5
		end
	end

	// bias low time counted only while driving on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			uv_cnt <= '0;
		end else if (ch.gate && ch.uv_en && ch.uv_raw) begin // R4 R8
			if (uv_cnt != CW'(QUAL_CYC)) uv_cnt <= uv_cnt + 1'b1;
		end else begin
			uv_cnt <= '0;
		end
	end

	assign ch.uv_hit = (uv_cnt == CW'(QUAL_CYC)); // R5
	// short compare valid only while this drive is on
	assign ch.sc_hit = ch.gate & ch.sc_en & ch.sc_raw; // R9 R10 R14

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	gate_follow_a: assert property (ch.cmd && !ch.kill |=> ch.gate) else $error("gate not on"); // R1
	kill_off_a: assert property (ch.kill |=> !ch.gate) else $error("gate not forced off"); // R3
	uv_idle_a: assert property (!ch.gate |=> uv_cnt == 0) else $error("uv counted while idle"); // R4
endmodule
`default_nettype wire

// ==== hdl/tpgd_top.sv ====
// Purpose: control and protection logic of a three-phase half-bridge gate driver
// Assumes: pins are asynchronous; config and sleep arrive from link logic on SYS_CLK
// Notes: channels 0..2 are high side, 3..5 low side
// Contract
// R1: each gate output follows its own PWM command input.
// R2: undriven PWM command reads low, so the gate stays off.
// R3: all gates low on fault, enable low over 1 ms, or sleep.
// R4: bias undervoltage only watched while that driver drives on.
// R5: qualified bias undervoltage refuses to turn the driver on.
// R6: bias undervoltage fault latches, pulls fault pin low, sends second status.
// R7: bias undervoltage fault clears only on power loss or enable low then high.
// R8: a config bit enables bias undervoltage lockout.
// R9: drop above short threshold on an active driver turns all drivers off.
// R10: high side compares supply to phase, low side phase to ground, when active.
// R11: short fault latches, pulls fault pin, reports, clears on enable rise.
// R12: two-bit field picks short threshold from 250, 500, 750, 1000 mV.
// R13: first configure command sets the threshold field.
// R14: a config bit enables short detection.
// R15: sleep needs enable low and sleep bit; all blocks off but wake.
// R16: standby keeps logic regulator, link, monitors; amplifiers by config.
// R17: overtemperature turns drivers off; link off 5 ms after its message.
// R18: power status set at power-up, supply undervoltage shutdown, wake.
// R19: standby when enable low over 1 ms and sleep bit clear.
// R20: sleep after both sleep command and enable low, either order.
// R21: enable rise clears a fault bit only if its cause ended; no repeat.
// R22: fault order: gates off, then fault pin, then message, unless overvoltage shutdown.
// R23: threshold codes 00 to 11 map to 250 up to 1000 mV.
// R24: enable low for 1 ms or less forces nothing.
`timescale 1ns/1ps
`default_nettype none
module tpgd_top #(
	parameter int OE_LOW_CYC = tpgd_pkg::TPGD_OE_LOW_CYC,
	parameter int LINK_OFF_CYC = tpgd_pkg::TPGD_LINK_OFF_CYC,
	parameter int UV_QUAL_CYC = tpgd_pkg::TPGD_UV_QUAL_CYC
) (
	input wire logic SYS_CLK, // system clock
	input wire logic RST, // async reset, high
	input wire logic [tpgd_pkg::TPGD_NCH-1:0] PWM_CMD, // gate commands, lo 3 high side
	input wire logic OUT_EN, // output enable pin
	input wire logic WAKE, // wake pin
	input wire logic [tpgd_pkg::TPGD_NCH-1:0] GATE_BIAS_UV, // bias below threshold
	input wire logic [tpgd_pkg::TPGD_NCH-1:0] SHORT_CMP, // drop above threshold
	input wire logic OVERTEMP, // overtemperature comparator
	input wire logic SUPPLY_OV_SHUTDOWN, // supply overvoltage shutdown
	input wire logic SUPPLY_UV_SHUTDOWN, // supply undervoltage shutdown
	input wire logic CFG_WR, // first configure command strobe
	input wire logic [7:0] CFG_DATA, // first configure command byte
	output logic [2:0] HIGH_SIDE_GATE_OUTPUTS, // high side gates
	output logic [2:0] LOW_SIDE_GATE_OUTPUTS, // low side gates
	output logic FAULT_N_O, // fault pin level when driven
	output logic FAULT_N_OE, // fault pin pull-down enable
	output logic MSG_STB, // status message pulse
	output logic [15:0] MSG_CODE, // status message bytes
	output logic [10:0] SHORT_THRESH_MV, // short threshold to comparators
	output logic LOGIC_REG_EN, // logic supply regulator on
	output logic GATE_BIAS_EN, // gate bias regulator on
	output logic LINK_EN, // host link on
	output logic AMP_EN, // amplifiers on
	output logic MON_EN, // supply and temperature monitors on
	output logic POWER_LOST, // configuration lost
	output logic [1:0] SYS_STATE // system state code
);
	import tpgd_pkg::*;
	localparam int NP = 3 * TPGD_NCH + 5;
	localparam int OW = $clog2(OE_LOW_CYC + 1);
	localparam int LW = $clog2(LINK_OFF_CYC + 1);

	initial begin
		if (OE_LOW_CYC < 1 || LINK_OFF_CYC < 1 || UV_QUAL_CYC < 1) $error("counts must be at least one");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [NP-1:0] pin_meta;
	logic [NP-1:0] pin_sync;
	logic [TPGD_NCH-1:0] pwm;
	logic [TPGD_NCH-1:0] uv_raw;
	logic [TPGD_NCH-1:0] sc_raw;
	logic oe, wake, ot, ovsd, uvsd;

	// two stages for every pin; the first stage feeds only the second
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {PWM_CMD, GATE_BIAS_UV, SHORT_CMP, OUT_EN, WAKE, OVERTEMP,
				SUPPLY_OV_SHUTDOWN, SUPPLY_UV_SHUTDOWN};
			pin_sync <= pin_meta;
		end
	end

	// undriven command pins are pulled low outside, reset state is low too
	assign {pwm, uv_raw, sc_raw, oe, wake, ot, ovsd, uvsd} = pin_sync; // R2

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	logic [1:0] thr_sel;
	logic sc_en, uv_en, amp_off, sleep_bit;
	tpgd_state_t state;
	logic wake_d;
	logic wake_up;

	assign wake_up = (state == TPGD_SLEEP) && wake && !wake_d;

	// configure command updates fields; wake restores defaults
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			thr_sel <= TPGD_CFG_RST[TPGD_CFG_THR_LSB +: 2];
			sc_en <= TPGD_CFG_RST[TPGD_CFG_SC_EN];
			uv_en <= TPGD_CFG_RST[TPGD_CFG_UV_EN];
			amp_off <= TPGD_CFG_RST[TPGD_CFG_AMP_OFF];
			sleep_bit <= TPGD_CFG_RST[TPGD_CFG_SLEEP];
		end else if (wake_up) begin
			thr_sel <= TPGD_CFG_RST[TPGD_CFG_THR_LSB +: 2];
			sc_en <= TPGD_CFG_RST[TPGD_CFG_SC_EN];
			uv_en <= TPGD_CFG_RST[TPGD_CFG_UV_EN];
			amp_off <= TPGD_CFG_RST[TPGD_CFG_AMP_OFF];
			sleep_bit <= TPGD_CFG_RST[TPGD_CFG_SLEEP];
		end else if (CFG_WR && state != TPGD_SLEEP) begin
			thr_sel <= CFG_DATA[TPGD_CFG_THR_LSB +: 2]; // R13
			sc_en <= CFG_DATA[TPGD_CFG_SC_EN]; // R14
			uv_en <= CFG_DATA[TPGD_CFG_UV_EN]; // R8
			amp_off <= CFG_DATA[TPGD_CFG_AMP_OFF];
			sleep_bit <= CFG_DATA[TPGD_CFG_SLEEP];
		end
	end

	// threshold to the analog comparators
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			SHORT_THRESH_MV <= TPGD_THR_MV[0];
		end else begin
			SHORT_THRESH_MV <= TPGD_THR_MV[thr_sel]; // R12 R23
		end
	end

	// ----------------------------------------
	// enable low timer and edges
	// ----------------------------------------
	logic [OW-1:0] oe_cnt;
	logic oe_d;
	logic oe_long;
	logic oe_rise;

	assign oe_long = (oe_cnt == OW'(OE_LOW_CYC));
	assign oe_rise = oe && !oe_d;

	// counts enable-low time; short pulses never reach the limit
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			oe_cnt <= '0;
		end else if (oe) begin
			oe_cnt <= '0;
		end else if (!oe_long) begin
			oe_cnt <= oe_cnt + 1'b1; // R24
		end
	end

	// edge history of enable and wake
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			oe_d <= 1'b0;
			wake_d <= 1'b0;
		end else begin
			oe_d <= oe;
			wake_d <= wake;
		end
	end

	// ----------------------------------------
	// driver channels
	// ----------------------------------------
	logic [TPGD_NCH-1:0] gate;
	logic [TPGD_NCH-1:0] uv_hit;
	logic [TPGD_NCH-1:0] sc_hit;
	logic uv_flt, sc_flt, ot_flt;
	logic fault_any;
	logic kill;

	assign fault_any = uv_flt | sc_flt | ot_flt | ovsd;
	// any hit kills all drivers at once, before any flag is seen
	assign kill = (|uv_hit) | (|sc_hit) | ot | fault_any | oe_long | (state == TPGD_SLEEP); // R3 R9 R17 R22

	for (genvar i = 0; i < TPGD_NCH; i++) begin : g_ch
		tpgd_chan_if chif();
		// high side raw compare is supply to phase, low side phase to ground
		assign chif.cmd = pwm[i];
		assign chif.kill = kill;
		assign chif.uv_en = uv_en;
		assign chif.sc_en = sc_en;
		assign chif.uv_raw = uv_raw[i];
		assign chif.sc_raw = sc_raw[i]; // R10
		assign gate[i] = chif.gate;
		assign uv_hit[i] = chif.uv_hit;
		assign sc_hit[i] = chif.sc_hit;
		tpgd_chan #(.QUAL_CYC(UV_QUAL_CYC)) u_chan (
			.clk(SYS_CLK),
			.rst(RST),
			.ch(chif)
		);
	end

	assign HIGH_SIDE_GATE_OUTPUTS = gate[2:0];
	assign LOW_SIDE_GATE_OUTPUTS = gate[5:3];

	// ----------------------------------------
	// fault latches
	// ----------------------------------------
	logic uv_set, sc_set, ot_set;
	assign uv_set = |uv_hit;
	assign sc_set = |sc_hit;
	assign ot_set = ot && !ot_flt;

	// set wins; enable rise clears only when the cause is gone
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			uv_flt <= 1'b0;
			sc_flt <= 1'b0;
			ot_flt <= 1'b0;
		end else begin
			uv_flt <= uv_set | (uv_flt & ~(oe_rise & ~(|uv_raw))); // R6 R7 R21
			sc_flt <= sc_set | (sc_flt & ~(oe_rise & ~(|sc_raw))); // R11 R21
			ot_flt <= ot | (ot_flt & ~oe_rise); // R17 R21
		end
	end

	// fault pin pulls low only once every gate is dark, so it never leads the drivers
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			FAULT_N_O <= 1'b0;
			FAULT_N_OE <= 1'b0;
		end else begin
			FAULT_N_O <= 1'b0;
			FAULT_N_OE <= fault_any & ~(|gate); // R6 R11 R22
		end
	end

	// ----------------------------------------
	// status messages
	// ----------------------------------------
	logic uv_new, sc_new, ot_pend, s1_pend;
	logic pin_seen;

	// only fresh latches raise a message; a held fault sends none again
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			uv_new <= 1'b0;
			sc_new <= 1'b0;
			pin_seen <= 1'b0;
			ot_pend <= 1'b0;
			s1_pend <= 1'b0;
		end else begin
			uv_new <= uv_set && !uv_flt;
			sc_new <= sc_set && !sc_flt;
			pin_seen <= ot_set;
			ot_pend <= pin_seen | (ot_pend & ~(MSG_STB & MSG_CODE[15:8] == TPGD_STAT0_ID)); // R21
			s1_pend <= uv_new | sc_new | (s1_pend & ~(MSG_STB & MSG_CODE[15:8] == TPGD_STAT1_ID)); // R22
		end
	end

	// at most one message every other cycle, sent after the fault pin has moved
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MSG_STB <= 1'b0;
			MSG_CODE <= '0;
		end else begin
			MSG_STB <= 1'b0;
			if (LINK_EN && !MSG_STB && ot_pend) begin
				MSG_STB <= 1'b1;
				MSG_CODE <= {TPGD_STAT0_ID, TPGD_OT_BITS}; // R17
			end else if (LINK_EN && !MSG_STB && s1_pend) begin
				MSG_STB <= 1'b1;
				MSG_CODE <= {TPGD_STAT1_ID, 4'h0, sc_flt, uv_flt, 2'h0}; // R6 R11
			end
		end
	end

	// ----------------------------------------
	// link shutdown after overtemperature
	// ----------------------------------------
	logic [LW-1:0] lnk_cnt;
	logic lnk_run, lnk_dead;

	// timer starts at the overtemperature message, stops link at its end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			lnk_cnt <= '0;
			lnk_run <= 1'b0;
			lnk_dead <= 1'b0;
		end else if (!ot_flt) begin
			lnk_cnt <= '0;
			lnk_run <= 1'b0;
			lnk_dead <= 1'b0;
		end else if (MSG_STB && MSG_CODE[15:8] == TPGD_STAT0_ID) begin
			lnk_run <= 1'b1;
		end else if (lnk_run) begin
			if (lnk_cnt == LW'(LINK_OFF_CYC - 1)) begin
				lnk_run <= 1'b0;
				lnk_dead <= 1'b1; // R17
			end else begin
				lnk_cnt <= lnk_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// system state
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state <= TPGD_OPER;
		end else begin
			case (state)
				TPGD_OPER: begin
					if (sleep_bit && !oe) state <= TPGD_SLEEP; // R20
					else if (oe_long) state <= TPGD_STBY; // R19
				end
				TPGD_STBY: begin
					if (sleep_bit && !oe) state <= TPGD_SLEEP; // R20
					else if (oe) state <= TPGD_OPER;
				end
				TPGD_SLEEP: begin
					if (wake_up) state <= TPGD_STBY;
				end
				default: state <= TPGD_OPER;
			endcase
		end
	end

	// power status set wins over the clearing configure command
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			POWER_LOST <= 1'b1; // R18
		end else begin
			POWER_LOST <= wake_up | uvsd | (POWER_LOST & ~CFG_WR); // R18
		end
	end

	// block enables by state
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			LOGIC_REG_EN <= 1'b0;
			GATE_BIAS_EN <= 1'b0;
			LINK_EN <= 1'b0;
			AMP_EN <= 1'b0;
			MON_EN <= 1'b0;
			SYS_STATE <= TPGD_OPER;
		end else begin
			LOGIC_REG_EN <= (state != TPGD_SLEEP) && !ovsd && !uvsd; // R15 R16
			GATE_BIAS_EN <= (state == TPGD_OPER) && !ot_flt; // R15
			LINK_EN <= (state != TPGD_SLEEP) && !lnk_dead && !ovsd; // R15 R16 R17
			AMP_EN <= (state == TPGD_OPER) || (state == TPGD_STBY && !amp_off); // R16
			MON_EN <= (state != TPGD_SLEEP); // R15 R16
			SYS_STATE <= state;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence gates_dark_s;
		gate == '0 && sc_flt;
	endsequence
	sequence pin_then_msg_s;
		FAULT_N_OE ##1 (MSG_STB && MSG_CODE[15:8] == TPGD_STAT1_ID);
	endsequence
	fault_order_a: assert property (sc_set && !sc_flt && !ot_pend && !ot |=> gates_dark_s ##1 pin_then_msg_s)
		else $error("fault sequence out of order"); // R22
	fault_pin_a: assert property (fault_any && gate == '0 |=> FAULT_N_OE) else $error("fault pin not low"); // R6
	hold_cause_a: assert property (uv_flt && (|uv_raw) |=> uv_flt) else $error("fault cleared early"); // R21
	sleep_entry_a: assert property (sleep_bit && !oe && state != TPGD_SLEEP |=> state == TPGD_SLEEP)
		else $error("sleep not entered"); // R20
	sleep_dark_a: assert property (state == TPGD_SLEEP |=> gate == '0 && !LINK_EN) else $error("sleep not dark"); // R15
	short_oe_a: assert property (oe_cnt < OW'(OE_LOW_CYC) && !oe |-> state != TPGD_STBY || $past(state) != TPGD_OPER)
		else $error("standby too early"); // R24
	wake_lost_a: assert property (wake_up |=> POWER_LOST) else $error("power status missed"); // R18
	thr_map_a: assert property (CFG_WR && state != TPGD_SLEEP && !wake_up |=> ##1
		SHORT_THRESH_MV == TPGD_THR_MV[$past(CFG_DATA[1:0], 2)]) else $error("threshold map wrong"); // R23
endmodule
`default_nettype wire

// ==== testbench/tpgd_host_model.sv ====
// Purpose: host controller model driving gate commands, enable and configure commands
// Assumes: requests change just after a rising edge of the system clock
// Notes: captures every status message the block sends
`timescale 1ns/1ps
`default_nettype none
module tpgd_host_model (
	input wire logic sys_clk, // system clock
	output logic [5:0] pwm_cmd, // gate commands
	output logic out_en, // output enable
	output logic cfg_wr, // configure strobe
	output logic [7:0] cfg_data, // configure byte
	input wire logic msg_stb, // status message pulse
	input wire logic [15:0] msg_code // status message bytes
);
	int msg_count;
	logic [15:0] last_msg;
	// idle levels; a command that is not driven reads low
	initial begin
		pwm_cmd = 6'h00;
		out_en = 1'b1;
		cfg_wr = 1'b0;
		cfg_data = 8'h00;
		msg_count = 0;
		last_msg = 16'h0000;
	end
	// message receiver, sampled while the pulse stands
	always @(posedge sys_clk) begin
		if (msg_stb === 1'b1) begin
			msg_count <= msg_count + 1;
			last_msg <= msg_code;
		end
	end
	task automatic set_pwm(input logic [5:0] v);
		@(posedge sys_clk);
		pwm_cmd <= v;
	endtask
	task automatic set_oe(input logic v);
		@(posedge sys_clk);
		out_en <= v;
	endtask
	// configure command: one strobe cycle, data scrambled once released
	task automatic write_cfg(input logic [7:0] b);
		@(posedge sys_clk);
		cfg_wr <= 1'b1;
		cfg_data <= b;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		cfg_data <= ~b;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_three_phase_gate_drive_protect.sv ====
// Purpose: self-checking bench of the gate drive protection block
// Assumes: shortened counts: enable low 20, link off 30, bias qualify 4 cycles
// Notes: supply shutdown inputs are exercised last
`timescale 1ns/1ps
`default_nettype none
module tb_three_phase_gate_drive_protect;
	import tpgd_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST, WAKE, OVERTEMP, SUP_OV, SUP_UV;
	logic [5:0] GATE_BIAS_UV, SHORT_CMP;
	logic [5:0] pwm, hs_ls;
	logic oe, cfg_wr, msg_stb, fault_oe, fault_o, power_lost;
	logic [7:0] cfg_data;
	logic [15:0] msg_code;
	logic [10:0] thr;
	logic [2:0] hs, ls;
	logic [4:0] en;
	logic [1:0] st;
	int mismatches = 0;
	int num_checks = 0;
	int n;
	assign hs_ls = {ls, hs};
	always #50 SYS_CLK = ~SYS_CLK;
	tpgd_host_model i_host (.sys_clk(SYS_CLK), .pwm_cmd(pwm), .out_en(oe), .cfg_wr(cfg_wr),
		.cfg_data(cfg_data), .msg_stb(msg_stb), .msg_code(msg_code));
	tpgd_top #(.OE_LOW_CYC(20), .LINK_OFF_CYC(30), .UV_QUAL_CYC(4)) i_dut (.SYS_CLK(SYS_CLK), .RST(RST),
		.PWM_CMD(pwm), .OUT_EN(oe), .WAKE(WAKE), .GATE_BIAS_UV(GATE_BIAS_UV), .SHORT_CMP(SHORT_CMP),
		.OVERTEMP(OVERTEMP), .SUPPLY_OV_SHUTDOWN(SUP_OV), .SUPPLY_UV_SHUTDOWN(SUP_UV), .CFG_WR(cfg_wr),
		.CFG_DATA(cfg_data), .HIGH_SIDE_GATE_OUTPUTS(hs), .LOW_SIDE_GATE_OUTPUTS(ls), .FAULT_N_O(fault_o),
		.FAULT_N_OE(fault_oe), .MSG_STB(msg_stb), .MSG_CODE(msg_code), .SHORT_THRESH_MV(thr),
		.LOGIC_REG_EN(en[4]), .GATE_BIAS_EN(en[3]), .LINK_EN(en[2]), .AMP_EN(en[1]), .MON_EN(en[0]),
		.POWER_LOST(power_lost), .SYS_STATE(st));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic nx(input int k);
		repeat (k) @(negedge SYS_CLK);
	endtask
	// gates drop first, then the pin, then one message
	task automatic fault_seq(input logic [15:0] exp);
		int i;
		n = i_host.msg_count;
		for (i = 0; i < 20 && fault_oe !== 1'b1; i++) nx(1);
		chk(16'(hs_ls), 16'h0000);
		chk(16'(i_host.msg_count - n), 16'h0000);
		for (i = 0; i < 20 && i_host.msg_count == n; i++) nx(1);
		chk(i_host.last_msg, exp);
		chk(16'(fault_oe), 16'h0001);
	endtask
	task automatic oe_pulse();
		i_host.set_oe(1'b0);
		nx(5);
		i_host.set_oe(1'b1);
		nx(6);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// watchdog, far beyond the expected run of under a thousand cycles
	initial begin
		#500000;
		mismatches++;
		complete_run();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		// idle levels of the analog and pin inputs, reset held for six clocks
		RST = 1'b1;
		WAKE = 1'b0;
		OVERTEMP = 1'b0;
		SUP_OV = 1'b0;
		SUP_UV = 1'b0;
		GATE_BIAS_UV = 6'h00;
		SHORT_CMP = 6'h00;
		repeat (6) @(posedge SYS_CLK);
		RST <= 1'b0;
		nx(1);
		chk(16'(thr), 16'h00fa);
		chk(16'(power_lost), 16'h0001);
		nx(3);
		chk(16'(en), 16'h001f);
		chk(16'(st), 16'(TPGD_OPER));
		// each command drives only its own gate
		for (int i = 0; i < 6; i++) begin
			i_host.set_pwm(6'h01 << i);
			nx(4);
			chk(16'(hs_ls), 16'(6'h01 << i));
		end
		i_host.set_pwm(6'h00);
		nx(4);
		chk(16'(hs_ls), 16'h0000);
		// every threshold code
		for (int c = 0; c < 4; c++) begin
			i_host.write_cfg(8'h0c | 8'(c));
			nx(4);
			chk(16'(thr), 16'(250 * (c + 1)));
		end
		chk(16'(power_lost), 16'h0000);
		// short enable low pulse changes nothing
		i_host.set_pwm(6'h09);
		i_host.set_oe(1'b0);
		nx(15);
		chk(16'(hs_ls), 16'h0009);
		chk(16'(st), 16'(TPGD_OPER));
		i_host.set_oe(1'b1);
		// protections disabled, and inactive drivers unwatched
		i_host.write_cfg(8'h40);
		@(posedge SYS_CLK);
		SHORT_CMP <= 6'h09;
		GATE_BIAS_UV <= 6'h09;
		nx(12);
		chk(16'(hs_ls), 16'h0009);
		i_host.set_pwm(6'h00);
		nx(4);
		i_host.write_cfg(8'h4c);
		@(posedge SYS_CLK);
		SHORT_CMP <= 6'h3f;
		GATE_BIAS_UV <= 6'h3f;
		nx(12);
		chk(16'(fault_oe), 16'h0000);
		@(posedge SYS_CLK);
		SHORT_CMP <= 6'h00;
		GATE_BIAS_UV <= 6'h00;
		// long enable low: standby, amplifiers off by config
		i_host.set_pwm(6'h09);
		i_host.set_oe(1'b0);
		nx(30);
		chk(16'(st), 16'(TPGD_STBY));
		chk(16'(hs_ls), 16'h0000);
		chk(16'(en), 16'h0015);
		i_host.set_oe(1'b1);
		nx(6);
		chk(16'(st), 16'(TPGD_OPER));
		chk(16'(hs_ls), 16'h0009);
		// low side short with the gate on
		@(posedge SYS_CLK);
		SHORT_CMP <= 6'h08;
		fault_seq({TPGD_STAT1_ID, 8'h08});
		oe_pulse();
		chk(16'(fault_oe), 16'h0001);
		chk(16'(i_host.msg_count - n), 16'h0001);
		@(posedge SYS_CLK);
		SHORT_CMP <= 6'h00;
		oe_pulse();
		chk(16'(fault_oe), 16'h0000);
		chk(16'(hs_ls), 16'h0009);
		// bias undervoltage on a high side gate
		@(posedge SYS_CLK);
		GATE_BIAS_UV <= 6'h01;
		fault_seq({TPGD_STAT1_ID, 8'h04});
		@(posedge SYS_CLK);
		GATE_BIAS_UV <= 6'h00;
		oe_pulse();
		chk(16'(fault_oe), 16'h0000);
		chk(16'(hs_ls), 16'h0009);
		// overtemperature: link stays up for its delay, then drops
		@(posedge SYS_CLK);
		OVERTEMP <= 1'b1;
		fault_seq({TPGD_STAT0_ID, TPGD_OT_BITS});
		nx(30);
		chk(16'(en[2]), 16'h0001);
		nx(1);
		chk(16'(en[2]), 16'h0000);
		@(posedge SYS_CLK);
		OVERTEMP <= 1'b0;
		oe_pulse();
		chk(16'(fault_oe), 16'h0000);
		// sleep: enable low first, command second
		i_host.set_oe(1'b0);
		i_host.write_cfg(8'h8d);
		nx(6);
		chk(16'(st), 16'(TPGD_SLEEP));
		chk(16'(en), 16'h0000);
		chk(16'(hs_ls), 16'h0000);
		@(posedge SYS_CLK);
		WAKE <= 1'b1;
		nx(6);
		chk(16'(st), 16'(TPGD_STBY));
		chk(16'(power_lost), 16'h0001);
		chk(16'(thr), 16'h00fa);
		@(posedge SYS_CLK);
		WAKE <= 1'b0;
		i_host.set_oe(1'b1);
		nx(6);
		chk(16'(st), 16'(TPGD_OPER));
		// supply undervoltage shutdown marks the configuration lost
		i_host.write_cfg(8'h0c);
		nx(2);
		chk(16'(power_lost), 16'h0000);
		@(posedge SYS_CLK);
		SUP_UV <= 1'b1;
		nx(4);
		chk(16'(power_lost), 16'h0001);
		@(posedge SYS_CLK);
		SUP_UV <= 1'b0;
		// overvoltage shutdown: gates off, then the pin, link down, no message
		n = i_host.msg_count;
		@(posedge SYS_CLK);
		SUP_OV <= 1'b1;
		nx(5);
		chk(16'(hs_ls), 16'h0000);
		chk(16'({fault_oe, fault_o}), 16'h0002);
		chk(16'(en[2]), 16'h0000);
		@(posedge SYS_CLK);
		SUP_OV <= 1'b0;
		nx(5);
		chk(16'(fault_oe), 16'h0000);
		chk(16'(hs_ls), 16'h0009);
		chk(16'(i_host.msg_count - n), 16'h0000);
		complete_run();
	end
endmodule
`default_nettype wire
